// file: src/uor_pkg.sv
package uor_pkg;
  // Register addresses on the register access port
  localparam logic [5:0] UOR_ADDR_IFC_CTRL = 6'h07;
  localparam logic [5:0] UOR_ADDR_IFC_SET = 6'h08;
  localparam logic [5:0] UOR_ADDR_IFC_CLR = 6'h09;
  localparam logic [5:0] UOR_ADDR_VID_CTRL = 6'h0A;
  localparam logic [5:0] UOR_ADDR_VID_SET = 6'h0B;
  localparam logic [5:0] UOR_ADDR_VID_CLR = 6'h0C;
  localparam logic [5:0] UOR_ADDR_RISE_EN = 6'h0D;
  // Control field positions
  localparam int UOR_BIT_VALID_SRC = 7;
  localparam int UOR_BIT_SUPPLY_SRC = 6;
  localparam int UOR_BIT_DRIVE = 5;
  localparam int UOR_BIT_CHARGE = 4;
  localparam int UOR_BIT_DISCHARGE = 3;
  localparam int UOR_BIT_DM_PD = 2;
  localparam int UOR_BIT_DP_PD = 1;
  localparam int UOR_BIT_ID_PULL = 0;
  // Event source positions
  localparam int UOR_EV_IDGND = 4;
  localparam int UOR_EV_HOSTDISC = 0;
  localparam int UOR_NUM_EV = 5;
  // Reset values
  localparam logic [7:0] UOR_RST_IFC = 8'h00;
  localparam logic [7:0] UOR_RST_VID = 8'h06;
  localparam logic [4:0] UOR_RST_RISE = 5'h1F;
  localparam logic [7:0] UOR_ZERO8 = 8'h00;
  // ID settle window
  localparam int UOR_CLK_MHZ = 100;
  localparam int UOR_ID_SETTLE_MS = 50;
  localparam int UOR_ID_SETTLE_CYC = UOR_ID_SETTLE_MS * 1000 * UOR_CLK_MHZ;
endpackage

// file: src/uor_regs.sv
// Functional notes
// - Write one at 0x09 clears interface bit
// - Bit 7 picks comparator or fault pin
// - Bit 6 external supply is stored but drives no output
// - Bit 5 drive request asserts power switch
// - Bit 4 enables resistor charging of VBUS
// - Bit 3 enables resistor discharge of VBUS
// - Bits 2,1 connect line pulldowns, reset one
// - Bit 0 strong pullup and sampling
// - Accessory detect states force strong pullup
// - Write one at 0x0B sets control bit
// - Write one at 0x0C clears control bit
// - Enabled rising edges raise events, reset one
// - Enable bits 4..0 mapped, 7..5 zero
// - Id events masked off and 50ms after
// - Disconnect events only in host mode
module uor_regs #(
  parameter int ID_SETTLE_CYC = uor_pkg::UOR_ID_SETTLE_CYC
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic fault_in,
  input wire logic vbus_valid_cmp_in,
  input wire logic id_weak_sample_enable_in,
  input wire logic accessory_charger_detect_en_in,
  input wire logic accessory_detect_state_in,
  input wire logic accessory_setup_state_in,
  input wire logic [uor_pkg::UOR_NUM_EV-1:0] event_src_in,
  output logic [7:0] interface_control_out,
  output logic vbus_valid_out,
  output logic power_switch_output_out,
  output logic vbus_charge_enable_out,
  output logic vbus_discharge_enable_out,
  output logic minus_line_pulldown_en_out,
  output logic plus_line_pulldown_en_out,
  output logic id_strong_resistor_out,
  output logic id_weak_resistor_out,
  output logic id_sample_out,
  output logic [uor_pkg::UOR_NUM_EV-1:0] rise_event_out
);
  import uor_pkg::*;

  logic [7:0] ifc_r;
  logic [7:0] vid_r;
  logic [4:0] rise_en_r;
  logic [4:0] src_d_r;
  logic [31:0] settle_cnt_r;
  logic id_masked;
  logic host_mode;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  // Each alias updates the one base flop, so effect lands in the same write
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
      ifc_r <= UOR_RST_IFC;
    else if (reg_wr_in && reg_addr_in == UOR_ADDR_IFC_CTRL)
      ifc_r <= reg_wdata_in;
    else if (reg_wr_in && reg_addr_in == UOR_ADDR_IFC_SET)
      ifc_r <= ifc_r | reg_wdata_in;
    else if (reg_wr_in && reg_addr_in == UOR_ADDR_IFC_CLR)
      ifc_r <= ifc_r & ~reg_wdata_in;
  end

  // Control register with set and clear aliases
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
      vid_r <= UOR_RST_VID;
    else if (reg_wr_in && reg_addr_in == UOR_ADDR_VID_CTRL)
      vid_r <= reg_wdata_in;
    else if (reg_wr_in && reg_addr_in == UOR_ADDR_VID_SET)
      vid_r <= vid_r | reg_wdata_in;
    else if (reg_wr_in && reg_addr_in == UOR_ADDR_VID_CLR)
      vid_r <= vid_r & ~reg_wdata_in;
  end

  // Rising enables; reserved upper bits are not stored
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
      rise_en_r <= UOR_RST_RISE;
    else if (reg_wr_in && reg_addr_in == UOR_ADDR_RISE_EN)
      rise_en_r <= reg_wdata_in[UOR_NUM_EV-1:0];
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Data registered one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
      reg_rdata_out <= UOR_ZERO8;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        UOR_ADDR_IFC_CTRL, UOR_ADDR_IFC_SET, UOR_ADDR_IFC_CLR: reg_rdata_out <= ifc_r;
        UOR_ADDR_VID_CTRL, UOR_ADDR_VID_SET, UOR_ADDR_VID_CLR: reg_rdata_out <= vid_r;
        UOR_ADDR_RISE_EN: reg_rdata_out <= {3'h0, rise_en_r};
        default: reg_rdata_out <= UOR_ZERO8;
      endcase
    end
  end

  // ----------------------------------------
  // VBUS and line control outputs
  // ----------------------------------------
  // Internal pump is absent, so only the drive bit matters for the switch
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
    begin
      interface_control_out <= UOR_RST_IFC;
      vbus_valid_out <= 1'b0;
      power_switch_output_out <= 1'b0;
      vbus_charge_enable_out <= 1'b0;
      vbus_discharge_enable_out <= 1'b0;
      minus_line_pulldown_en_out <= UOR_RST_VID[UOR_BIT_DM_PD];
      plus_line_pulldown_en_out <= UOR_RST_VID[UOR_BIT_DP_PD];
    end
    else
    begin
      interface_control_out <= ifc_r;
      vbus_valid_out <= vid_r[UOR_BIT_VALID_SRC] ? fault_in : vbus_valid_cmp_in;
      power_switch_output_out <= vid_r[UOR_BIT_DRIVE];
      vbus_charge_enable_out <= vid_r[UOR_BIT_CHARGE];
      vbus_discharge_enable_out <= vid_r[UOR_BIT_DISCHARGE];
      minus_line_pulldown_en_out <= vid_r[UOR_BIT_DM_PD];
      plus_line_pulldown_en_out <= vid_r[UOR_BIT_DP_PD];
    end
  end

  // ID pullups; accessory states force the strong pullup, weak pullup still follows the control bit
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
    begin
      id_strong_resistor_out <= UOR_RST_VID[UOR_BIT_ID_PULL];
      id_weak_resistor_out <= !UOR_RST_VID[UOR_BIT_ID_PULL];
      id_sample_out <= 1'b0;
    end
    else
    begin
      id_strong_resistor_out <= vid_r[UOR_BIT_ID_PULL] || (accessory_charger_detect_en_in &&
        (accessory_detect_state_in || accessory_setup_state_in));
      id_weak_resistor_out <= !vid_r[UOR_BIT_ID_PULL];
      id_sample_out <= vid_r[UOR_BIT_ID_PULL] || id_weak_sample_enable_in;
    end
  end

  // ----------------------------------------
  // Event generation
  // ----------------------------------------
  // Settle counter restarts whenever the pullup bit is low
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in || !vid_r[UOR_BIT_ID_PULL])
      settle_cnt_r <= 32'h0;
    else if (settle_cnt_r < 32'(ID_SETTLE_CYC))
      settle_cnt_r <= settle_cnt_r + 32'h1;
  end

  assign id_masked = !vid_r[UOR_BIT_ID_PULL] || (settle_cnt_r < 32'(ID_SETTLE_CYC));
  assign host_mode = vid_r[UOR_BIT_DM_PD] && vid_r[UOR_BIT_DP_PD];

  // Delayed source copy for edge detect
  // Tracks the pins through reset too, so a source already high is no false edge
  always_ff @(posedge clock_in)
  begin
    src_d_r <= event_src_in;
  end

  // One flop per source; pulses last one cycle
  for (genvar g = 0; g < UOR_NUM_EV; g++)
  begin : g_ev
    logic gate;
    if (g == UOR_EV_IDGND)
    begin : g_id
      assign gate = !id_masked;
    end
    else if (g == UOR_EV_HOSTDISC)
    begin : g_hd
      assign gate = host_mode;
    end
    else
    begin : g_pl
      assign gate = 1'b1;
    end
    always_ff @(posedge clock_in)
    begin
      if (!rstn_in)
        rise_event_out[g] <= 1'b0;
      else
        rise_event_out[g] <= rise_en_r[g] && gate && event_src_in[g] && !src_d_r[g];
    end
  end
endmodule // uor_regs

// file: test/uor_link_model.sv
module uor_link_model (
  input wire logic clock_in,
  input wire logic [7:0] reg_rdata_in,
  output logic reg_wr_out = 1'b0,
  output logic reg_rd_out = 1'b0,
  output logic [5:0] reg_addr_out = 6'h00,
  output logic [7:0] reg_wdata_out = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // One access per call, entered just after a rising edge
  task automatic access(input logic wr, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    reg_wr_out <= wr;
    reg_rd_out <= !wr;
    reg_addr_out <= a;
    reg_wdata_out <= d;
    @(posedge clock_in);
    reg_wr_out <= 1'b0;
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a; // Released bus must not echo the last value
    reg_wdata_out <= ~d;
    @(posedge clock_in);
    q = reg_rdata_in;
  endtask
endmodule // uor_link_model

// file: test/uor_regs_sva.sv
module uor_regs_sva
  import uor_pkg::*;
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic accessory_charger_detect_en_in,
  input wire logic accessory_detect_state_in,
  input wire logic [4:0] rise_event_out,
  input wire logic [4:0] event_src_in,
  input wire logic [7:0] interface_control_out,
  input wire logic power_switch_output_out,
  input wire logic vbus_charge_enable_out,
  input wire logic vbus_discharge_enable_out,
  input wire logic minus_line_pulldown_en_out,
  input wire logic plus_line_pulldown_en_out,
  input wire logic id_strong_resistor_out,
  input wire logic id_weak_resistor_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  logic vid_rd;
  // Read-back of the control register lines up with the output flops
  assign vid_rd = reg_rd_in && reg_addr_in == UOR_ADDR_VID_CTRL;
  a_ifc_clear: assert property (reg_wr_in && reg_addr_in == UOR_ADDR_IFC_CLR ##1 !reg_wr_in |=>
    (interface_control_out & $past(reg_wdata_in, 2)) == UOR_ZERO8) else $error("clear alias left a bit set");
  a_vid_readback: assert property (vid_rd |=> reg_rdata_out[5:1] == {power_switch_output_out,
    vbus_charge_enable_out, vbus_discharge_enable_out, minus_line_pulldown_en_out, plus_line_pulldown_en_out})
    else $error("control outputs differ from read-back");
  a_id_weak: assert property (vid_rd |=> reg_rdata_out[0] != id_weak_resistor_out)
    else $error("weak pullup not opposite of strong bit");
  a_aca_force: assert property ((accessory_charger_detect_en_in && accessory_detect_state_in)[*2] |=>
    id_strong_resistor_out) else $error("strong pullup not forced");
  a_rise_edge: assert property (rise_event_out[3] |-> $past(event_src_in[3]) && !$past(event_src_in[3], 2))
    else $error("event without a rising source");
  a_rsvd_zero: assert property (reg_rd_in && reg_addr_in == UOR_ADDR_RISE_EN |=> reg_rdata_out[7:5] == 3'h0)
    else $error("reserved enable bits read nonzero");
  a_id_mask: assert property (rise_event_out[UOR_EV_IDGND] |-> !id_weak_resistor_out &&
    !$past(id_weak_resistor_out, 16)) else $error("id event inside mask window");
  a_host_only: assert property (rise_event_out[UOR_EV_HOSTDISC] |-> minus_line_pulldown_en_out &&
    plus_line_pulldown_en_out) else $error("disconnect event outside host mode");
endmodule // uor_regs_sva
bind uor_regs uor_regs_sva i_sva (.*);

// file: test/testbench.sv
module testbench import uor_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0, rstn_in = 1'b0, reg_wr_in, reg_rd_in, fault_in = 1'b1, vbus_valid_cmp_in = 1'b0;
  logic id_weak_sample_enable_in = 1'b0, accessory_charger_detect_en_in = 1'b0;
  logic accessory_detect_state_in = 1'b0, accessory_setup_state_in = 1'b0;
  logic [5:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, interface_control_out, q;
  logic [4:0] event_src_in = 5'h00, rise_event_out, seen;
  logic vbus_valid_out, power_switch_output_out, vbus_charge_enable_out, vbus_discharge_enable_out;
  logic minus_line_pulldown_en_out, plus_line_pulldown_en_out, id_strong_resistor_out, id_weak_resistor_out;
  logic id_sample_out;
  localparam logic [3:0] ACA [4] = '{4'hD, 4'hB, 4'h8, 4'h4};
  int miscompares = 0;
  int n_tests = 0;
  always #5 clock_in = ~clock_in;
  // Short settle window keeps the masking test brief
  uor_regs #(.ID_SETTLE_CYC(20)) i_dut (.*);
  uor_link_model i_link (.clock_in(clock_in), .reg_rdata_in(reg_rdata_out), .reg_wr_out(reg_wr_in),
    .reg_rd_out(reg_rd_in), .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in));
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    i_link.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    i_link.access(1'b0, a, 8'h00, q);
    check("read data", q, e);
  endtask
  // Raise every source once and collect the pulses that come back
  task automatic fire(input logic [4:0] e);
    seen = 5'h00;
    event_src_in <= 5'h1F;
    repeat (4)
    begin
      @(negedge clock_in);
      seen = seen | rise_event_out;
    end
    @(posedge clock_in);
    event_src_in <= 5'h00;
    @(posedge clock_in);
    check("rise events", 8'(seen), 8'(e));
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    rd(UOR_ADDR_VID_CTRL, UOR_RST_VID);
    rd(UOR_ADDR_RISE_EN, 8'(UOR_RST_RISE));
    rd(6'h3F, UOR_ZERO8);
    check("reset pins", 8'({minus_line_pulldown_en_out, plus_line_pulldown_en_out, id_weak_resistor_out}), 8'h07);
    wr(UOR_ADDR_VID_SET, 8'hFF);
    rd(UOR_ADDR_VID_CTRL, 8'hFF);
    check("vid pins", 8'({vbus_valid_out, power_switch_output_out, vbus_charge_enable_out, vbus_discharge_enable_out,
      id_strong_resistor_out}), 8'h1F);
    wr(UOR_ADDR_VID_CLR, 8'hB8);
    rd(UOR_ADDR_VID_CLR, 8'h47);
    check("vid pins", 8'({vbus_valid_out, power_switch_output_out, vbus_charge_enable_out}), 8'h00);
    wr(UOR_ADDR_IFC_SET, 8'hF0);
    wr(UOR_ADDR_IFC_CLR, 8'h30);
    rd(UOR_ADDR_IFC_CLR, 8'hC0);
    check("ifc copy", interface_control_out, 8'hC0);
    wr(UOR_ADDR_RISE_EN, 8'hE0);
    rd(UOR_ADDR_RISE_EN, UOR_ZERO8);
    wr(UOR_ADDR_RISE_EN, 8'hFF);
    rd(UOR_ADDR_RISE_EN, 8'h1F);
    fire(5'h1F);
    wr(UOR_ADDR_VID_CLR, 8'h03);
    fire(5'h0E);
    wr(UOR_ADDR_VID_SET, 8'h03);
    fire(5'h0F);
    repeat (25) @(posedge clock_in);
    fire(5'h1F);
    wr(UOR_ADDR_RISE_EN, 8'h06);
    fire(5'h06);
    wr(UOR_ADDR_VID_CLR, 8'h01);
    foreach (ACA[i])
    begin
      {accessory_charger_detect_en_in, accessory_detect_state_in, accessory_setup_state_in} <= ACA[i][3:1];
      repeat (3) @(posedge clock_in);
      check("id strong", 8'(id_strong_resistor_out), 8'(ACA[i][0]));
    end
    check("id sample", 8'(id_sample_out), 8'h00);
    id_weak_sample_enable_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    check("id sample", 8'(id_sample_out), 8'h01);
    // Mid-run reset with sources held high must not report a false edge
    event_src_in <= 5'h1F;
    rstn_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    seen = 5'h00;
    repeat (4)
    begin
      @(negedge clock_in);
      seen = seen | rise_event_out;
    end
    check("reset events", 8'(seen), UOR_ZERO8);
    @(posedge clock_in);
    event_src_in <= 5'h00;
    rd(UOR_ADDR_VID_CTRL, UOR_RST_VID);
    rd(UOR_ADDR_RISE_EN, 8'(UOR_RST_RISE));
    complete_run();
  end
endmodule // testbench
